//--- hdl/seq_pkg.sv
// shared constants and carrier types of the waveform step sequencer
package seq_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned STEP_W = 4;
  localparam int unsigned MEM_AW = 6;
  localparam int unsigned VAL_W  = 16;

  // register offsets, byte addresses
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_CMD       = 12'h004;
  localparam logic [11:0] OFF_STATUS    = 12'h008;
  localparam logic [11:0] OFF_NORM_FREQ = 12'h00C;
  localparam logic [11:0] OFF_NORM_AMP  = 12'h010;
  localparam logic [11:0] OFF_NORM_WAVE = 12'h014;
  localparam logic [11:0] OFF_STEP_MEM  = 12'h100;
  localparam logic [11:0] STEP_MEM_MASK = 12'hF00;

  // command register bit positions (write one to fire)
  localparam int unsigned CMD_START  = 0;
  localparam int unsigned CMD_STOP   = 1;
  localparam int unsigned CMD_RESUME = 2;
  localparam int unsigned CMD_IMMBR  = 3;

  // step table words, index inside a step
  localparam logic [1:0] WORD_TIME = 2'h0;
  localparam logic [1:0] WORD_CTL  = 2'h1;
  localparam logic [1:0] WORD_FREQ = 2'h2;
  localparam logic [1:0] WORD_AMP  = 2'h3;

  // field positions inside the frequency and amplitude words
  localparam int unsigned ACT_LSB   = 16;
  localparam int unsigned PHASE_LSB = 24;
  localparam int unsigned WAVE_LSB  = 20;

  // per-parameter action codes
  localparam logic [1:0] ACT_CONST = 2'h0;
  localparam logic [1:0] ACT_KEEP  = 2'h1;
  localparam logic [1:0] ACT_SWEEP = 2'h2;

  // reset value and last fetch count
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0]  FETCH_LAST = 3'h4;

  // step control word, bit 0 is hold_after_step
  typedef struct packed {
    logic [3:0] rsvdHi;
    logic [7:0] stepSyncCode;
    logic [3:0] immTarget;
    logic [3:0] levelTarget;
    logic [3:0] jumpTarget;
    logic [1:0] rsvdLo;
    logic       jumpEn;
    logic       immediateBranchEn;
    logic       levelBranchEn;
    logic       stopPhaseEn;
    logic       terminationEnd;
    logic       holdAfterStep;
  } stepCtl_s;

  typedef struct packed {
    logic [3:0]  wave;
    logic [15:0] freq;
    logic [15:0] amp;
  } chanOut_s;
endpackage

//--- hdl/step_mem.sv
// step table storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module step_mem (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wrEn,
  input  wire logic [5:0]  wrAddr,
  input  wire logic [31:0] wrData,
  input  wire logic [5:0]  rdAddr,
  output var  logic [31:0] rdData_ff
);
  logic [31:0] mem [0:63];

  // array has no reset: software loads the table before use
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData_ff <= seq_pkg::RST_WORD;
    end else begin
      rdData_ff <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

//--- hdl/waveform_step_sequencer.sv
// step sequencer driving the sequence-mode channel settings
//
// How it works
// - step 0 settings are output in standby, before start and after end
// - start from standby leaves step 0 and runs step 1
// - sweep ramps linearly from entry value to set value, arriving at step end
// - keep holds the value in force on entry for the whole step
// - const applies the set value on entry, jumping if needed
// - waveform is always applied on step entry, no action choice
// - elapsed step, no hold, continue termination: advance to next step
// - elapsed step with hold on: freeze output until stop or resume
// - stop while held goes to step 0 and ends the sequence
// - resume while held: end termination goes to step 0, continue goes onward
// - step 0 time and actions ignored at start, used only at end
// - after ending in step 0 stay standby; start reruns from beginning
// - sequence settings stored apart from normal oscillation settings
// - step control sets duration and successor and outputs a sync code
// - with stop phase, wait for reference phase after step time, unswept
// - level branch sampled only when step time has elapsed, then branch
// - immediate branch jumps at once, ignoring stop phase
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module waveform_step_sequencer (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [11:0]            addr,
  input  wire logic [31:0]            wrData,
  input  wire logic                   wrEn,
  input  wire logic                   rdEn,
  output var  logic [31:0]            rdData_ff,
  input  wire logic [7:0]             refPhase,
  input  wire logic                   levelBranchPin,
  input  wire logic                   immediateBranchPin,
  output var  seq_pkg::chanOut_s      outCh_ff,
  output var  logic [7:0]             stepSyncCode_ff,
  output var  logic [3:0]             curStep_ff
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_FETCH = 6'h02,
    ST_RUN   = 6'h04,
    ST_PHASE = 6'h08,
    ST_HELD  = 6'h10,
    ST_SNAP  = 6'h20
  } seqState_e;

  // linear interpolation a -> b at n of d; n == d gives b exactly
  function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
                                       input logic [31:0] n, input logic [31:0] d);
    logic signed [16:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] quot;
    diff = $signed({1'h0, b}) - $signed({1'h0, a});
    prod = diff * $signed({1'h0, n});
    quot = prod / $signed({1'h0, d});
    lerp = a + quot[15:0];
  endfunction

  // entry value of one parameter by its action
  function automatic logic [15:0] entryVal(input logic [1:0] act, input logic [15:0] cur,
                                           input logic [15:0] set);
    entryVal = (act == seq_pkg::ACT_CONST) ? set : cur;
  endfunction

  seqState_e          state_ff, nxt_state;
  logic [3:0]         stepIdx_ff, nxt_stepIdx;
  logic [2:0]         fetchCnt_ff, nxt_fetchCnt;
  logic               endFlag_ff, nxt_endFlag;
  logic [31:0]        time_ff, nxt_time;
  logic [31:0]        elapsed_ff, nxt_elapsed;
  seq_pkg::stepCtl_s  ctl_ff, nxt_ctl;
  logic [31:0]        freqWord_ff, nxt_freqWord;
  logic [31:0]        ampWord_ff, nxt_ampWord;
  seq_pkg::chanOut_s  seqCh_ff, nxt_seqCh;
  seq_pkg::chanOut_s  startCh_ff, nxt_startCh;
  logic [7:0]         nxt_syncCode;
  logic               seqMode_ff;
  seq_pkg::chanOut_s  normCh_ff;
  logic               modeRise_ff;
  logic [1:0]         levelSync_ff;
  logic [2:0]         immSync_ff;
  logic [31:0]        memRd;

  // register decode
  wire         wrCtrl    = wrEn && (addr == seq_pkg::OFF_CTRL);
  wire         wrCmd     = wrEn && (addr == seq_pkg::OFF_CMD);
  wire         wrMem     = wrEn && ((addr & seq_pkg::STEP_MEM_MASK) == seq_pkg::OFF_STEP_MEM);
  wire         cmdStart  = wrCmd && wrData[seq_pkg::CMD_START];
  wire         cmdStop   = wrCmd && wrData[seq_pkg::CMD_STOP];
  wire         cmdResume = wrCmd && wrData[seq_pkg::CMD_RESUME];
  wire         immEvent  = (wrCmd && wrData[seq_pkg::CMD_IMMBR]) || (immSync_ff[1] && !immSync_ff[2]);
  wire         levelNow  = levelSync_ff[1];
  wire [5:0]   memRdAddr = {stepIdx_ff, fetchCnt_ff[1:0]};
  wire [31:0]  timeDiv   = (time_ff == 32'h0000_0000) ? 32'h0000_0001 : time_ff;
  wire [31:0]  elapsedInc = elapsed_ff + 32'h0000_0001;
  wire         stepDone  = (elapsedInc >= timeDiv);
  wire [1:0]   freqAct   = freqWord_ff[seq_pkg::ACT_LSB +: 2];
  wire [1:0]   ampAct    = ampWord_ff[seq_pkg::ACT_LSB +: 2];
  wire [7:0]   stopPhase = freqWord_ff[seq_pkg::PHASE_LSB +: 8];
  wire [3:0]   seqNext   = ctl_ff.jumpEn ? ctl_ff.jumpTarget : stepIdx_ff + 4'h1;
  wire         levelHit  = ctl_ff.levelBranchEn && levelNow;
  wire         immHit    = ctl_ff.immediateBranchEn && immEvent && !endFlag_ff;
  wire         phaseMatch = (refPhase == stopPhase);

  logic [31:0] rdMux;
  always_comb begin
    case (addr)
      seq_pkg::OFF_CTRL:      rdMux = {31'h0000_0000, seqMode_ff};
      seq_pkg::OFF_STATUS:    rdMux = {19'h0_0000, endFlag_ff, state_ff, stepIdx_ff,
                                       levelNow, ctl_ff.holdAfterStep};
      seq_pkg::OFF_NORM_FREQ: rdMux = {16'h0000, normCh_ff.freq};
      seq_pkg::OFF_NORM_AMP:  rdMux = {16'h0000, normCh_ff.amp};
      seq_pkg::OFF_NORM_WAVE: rdMux = {28'h000_0000, normCh_ff.wave};
      default:                rdMux = 32'h0000_0000;
    endcase
  end

  step_mem u_mem (
    .clk       (clk),
    .nrst      (nrst),
    .wrEn      (wrMem),
    .wrAddr    (addr[7:2]),
    .wrData    (wrData),
    .rdAddr    (memRdAddr),
    .rdData_ff (memRd)
  );

  // sequencer next-state logic
  always_comb begin
    nxt_state    = state_ff;
    nxt_stepIdx  = stepIdx_ff;
    nxt_fetchCnt = 3'h0;
    nxt_endFlag  = endFlag_ff;
    nxt_time     = time_ff;
    nxt_elapsed  = elapsed_ff;
    nxt_ctl      = ctl_ff;
    nxt_freqWord = freqWord_ff;
    nxt_ampWord  = ampWord_ff;
    nxt_seqCh    = seqCh_ff;
    nxt_startCh  = startCh_ff;
    nxt_syncCode = stepSyncCode_ff;
    case (state_ff)
      ST_IDLE: begin
        if (modeRise_ff) begin
          nxt_state   = ST_SNAP;
          nxt_stepIdx = 4'h0;
        end else if (seqMode_ff && cmdStart) begin
          nxt_state   = ST_FETCH;
          nxt_stepIdx = 4'h1;
          nxt_endFlag = 1'h0;
        end
      end
      ST_FETCH, ST_SNAP: begin
        nxt_fetchCnt = fetchCnt_ff + 3'h1;
        case (fetchCnt_ff)
          3'h1: nxt_time = memRd;
          3'h2: nxt_ctl = seq_pkg::stepCtl_s'(memRd);
          3'h3: nxt_freqWord = memRd;
          default: nxt_ampWord = memRd;
        endcase
        if (fetchCnt_ff == seq_pkg::FETCH_LAST) begin
          nxt_fetchCnt     = 3'h0;
          nxt_seqCh.wave   = memRd[seq_pkg::WAVE_LSB +: 4];
          nxt_syncCode     = ctl_ff.stepSyncCode;
          nxt_startCh      = seqCh_ff;
          nxt_elapsed      = 32'h0000_0000;
          if (state_ff == ST_SNAP) begin
            nxt_seqCh.freq = freqWord_ff[15:0];
            nxt_seqCh.amp  = memRd[15:0];
            nxt_state      = ST_IDLE;
          end else begin
            nxt_seqCh.freq = entryVal(freqWord_ff[seq_pkg::ACT_LSB +: 2], seqCh_ff.freq,
                                      freqWord_ff[15:0]);
            nxt_seqCh.amp  = entryVal(memRd[seq_pkg::ACT_LSB +: 2], seqCh_ff.amp,
                                      memRd[15:0]);
            nxt_state      = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        nxt_elapsed = elapsedInc;
        if (freqAct == seq_pkg::ACT_SWEEP) begin
          nxt_seqCh.freq = lerp(startCh_ff.freq, freqWord_ff[15:0], elapsedInc, timeDiv);
        end
        if (ampAct == seq_pkg::ACT_SWEEP) begin
          nxt_seqCh.amp = lerp(startCh_ff.amp, ampWord_ff[15:0], elapsedInc, timeDiv);
        end
        if (immHit) begin
          nxt_state   = ST_FETCH;
          nxt_stepIdx = ctl_ff.immTarget;
          nxt_endFlag = (ctl_ff.immTarget == 4'h0);
        end else if (cmdStop && !endFlag_ff) begin
          nxt_state   = ST_FETCH;
          nxt_stepIdx = 4'h0;
          nxt_endFlag = 1'h1;
        end else if (stepDone) begin
          if (endFlag_ff) begin
            nxt_state = ST_IDLE;
          end else if (ctl_ff.stopPhaseEn) begin
            nxt_state = ST_PHASE;
          end else if (levelHit) begin
            nxt_state   = ST_FETCH;
            nxt_stepIdx = ctl_ff.levelTarget;
            nxt_endFlag = (ctl_ff.levelTarget == 4'h0);
          end else if (ctl_ff.holdAfterStep) begin
            nxt_state = ST_HELD;
          end else begin
            nxt_state   = ST_FETCH;
            nxt_stepIdx = ctl_ff.terminationEnd ? 4'h0 : seqNext;
            nxt_endFlag = ctl_ff.terminationEnd || (seqNext == 4'h0);
          end
        end
      end
      ST_PHASE: begin
        // output stays as it is while waiting for the phase
        if (immHit) begin
          nxt_state   = ST_FETCH;
          nxt_stepIdx = ctl_ff.immTarget;
          nxt_endFlag = (ctl_ff.immTarget == 4'h0);
        end else if (cmdStop) begin
          nxt_state   = ST_FETCH;
          nxt_stepIdx = 4'h0;
          nxt_endFlag = 1'h1;
        end else if (phaseMatch) begin
          if (levelHit) begin
            nxt_state   = ST_FETCH;
            nxt_stepIdx = ctl_ff.levelTarget;
            nxt_endFlag = (ctl_ff.levelTarget == 4'h0);
          end else if (ctl_ff.holdAfterStep) begin
            nxt_state = ST_HELD;
          end else begin
            nxt_state   = ST_FETCH;
            nxt_stepIdx = ctl_ff.terminationEnd ? 4'h0 : seqNext;
            nxt_endFlag = ctl_ff.terminationEnd || (seqNext == 4'h0);
          end
        end
      end
      ST_HELD: begin
        if (immHit) begin
          nxt_state   = ST_FETCH;
          nxt_stepIdx = ctl_ff.immTarget;
          nxt_endFlag = (ctl_ff.immTarget == 4'h0);
        end else if (cmdStop) begin
          nxt_state   = ST_FETCH;
          nxt_stepIdx = 4'h0;
          nxt_endFlag = 1'h1;
        end else if (cmdResume) begin
          nxt_state   = ST_FETCH;
          nxt_stepIdx = ctl_ff.terminationEnd ? 4'h0 : seqNext;
          nxt_endFlag = ctl_ff.terminationEnd || (seqNext == 4'h0);
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff        <= ST_IDLE;
      stepIdx_ff      <= 4'h0;
      fetchCnt_ff     <= 3'h0;
      endFlag_ff      <= 1'h0;
      time_ff         <= seq_pkg::RST_WORD;
      elapsed_ff      <= seq_pkg::RST_WORD;
      ctl_ff          <= seq_pkg::stepCtl_s'(seq_pkg::RST_WORD);
      freqWord_ff     <= seq_pkg::RST_WORD;
      ampWord_ff      <= seq_pkg::RST_WORD;
      seqCh_ff        <= '0;
      startCh_ff      <= '0;
      stepSyncCode_ff <= 8'h00;
    end else begin
      state_ff        <= nxt_state;
      stepIdx_ff      <= nxt_stepIdx;
      fetchCnt_ff     <= nxt_fetchCnt;
      endFlag_ff      <= nxt_endFlag;
      time_ff         <= nxt_time;
      elapsed_ff      <= nxt_elapsed;
      ctl_ff          <= nxt_ctl;
      freqWord_ff     <= nxt_freqWord;
      ampWord_ff      <= nxt_ampWord;
      seqCh_ff        <= nxt_seqCh;
      startCh_ff      <= nxt_startCh;
      stepSyncCode_ff <= nxt_syncCode;
    end
  end

  // normal-mode settings live apart from the step table
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seqMode_ff  <= 1'h0;
      modeRise_ff <= 1'h0;
      normCh_ff   <= '0;
    end else begin
      modeRise_ff <= wrCtrl && wrData[0] && !seqMode_ff;
      if (wrCtrl) seqMode_ff <= wrData[0];
      if (wrEn && addr == seq_pkg::OFF_NORM_FREQ) normCh_ff.freq <= wrData[15:0];
      if (wrEn && addr == seq_pkg::OFF_NORM_AMP) normCh_ff.amp <= wrData[15:0];
      if (wrEn && addr == seq_pkg::OFF_NORM_WAVE) normCh_ff.wave <= wrData[3:0];
    end
  end

  // pins cross into clk through two flops before use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      levelSync_ff <= 2'h0;
      immSync_ff   <= 3'h0;
    end else begin
      levelSync_ff <= {levelSync_ff[0], levelBranchPin};
      immSync_ff   <= {immSync_ff[1:0], immediateBranchPin};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      outCh_ff   <= '0;
      curStep_ff <= 4'h0;
      rdData_ff  <= seq_pkg::RST_WORD;
    end else begin
      outCh_ff   <= seqMode_ff ? seqCh_ff : normCh_ff;
      curStep_ff <= stepIdx_ff;
      rdData_ff  <= rdEn ? rdMux : seq_pkg::RST_WORD;
    end
  end

  AST_STANDBY_STEP0: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_IDLE |-> stepIdx_ff == 4'h0)
    else $error("standby not on step 0");
  AST_START_STEP1: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_IDLE && !modeRise_ff && seqMode_ff && cmdStart
    |=> state_ff == ST_FETCH && stepIdx_ff == 4'h1 ##5 state_ff == ST_RUN)
    else $error("start did not run step 1");
  AST_SWEEP_ARRIVE: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_RUN && stepDone && freqAct == seq_pkg::ACT_SWEEP
    |=> seqCh_ff.freq == $past(freqWord_ff[15:0]))
    else $error("sweep missed set value at step end");
  AST_KEEP_STABLE: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_RUN && freqAct == seq_pkg::ACT_KEEP |=> $stable(seqCh_ff.freq))
    else $error("kept value moved");
  AST_CONST_SET: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_RUN && ampAct == seq_pkg::ACT_CONST |-> seqCh_ff.amp == ampWord_ff[15:0])
    else $error("const value not applied");
  AST_WAVE_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_FETCH && fetchCnt_ff == seq_pkg::FETCH_LAST
    |=> seqCh_ff.wave == $past(memRd[seq_pkg::WAVE_LSB +: 4]))
    else $error("waveform not applied on entry");
  AST_HELD_FROZEN: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_HELD && !cmdStop && !cmdResume && !immHit
    |=> state_ff == ST_HELD && $stable(seqCh_ff))
    else $error("held output changed");
  AST_STOP_HELD: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_HELD && cmdStop && !immHit |=> state_ff == ST_FETCH && stepIdx_ff == 4'h0)
    else $error("stop while held not to step 0");
  AST_RESUME_HELD: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_HELD && cmdResume && !cmdStop && !immHit
    |=> stepIdx_ff == ($past(ctl_ff.terminationEnd) ? 4'h0 : $past(seqNext)))
    else $error("resume went to wrong step");
  AST_PHASE_WAIT: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_PHASE && !phaseMatch && !immHit && !cmdStop
    |=> state_ff == ST_PHASE && $stable(seqCh_ff))
    else $error("left stop phase wait early");
  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_RUN && !stepDone && !immHit && !cmdStop
    |=> state_ff == ST_RUN && elapsed_ff == $past(elapsed_ff) + 32'h0000_0001)
    else $error("step counter did not advance");
  AST_NORMAL_APART: assert property (@(posedge clk) disable iff (!nrst)
    !seqMode_ff |=> outCh_ff == $past(normCh_ff))
    else $error("normal settings not on output");
endmodule
`default_nettype wire

//--- tb/branch_src.sv
// generator-side source of reference phase and branch pins
`timescale 1ns/1ps
`default_nettype none
module branch_src (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       fire,
  input  wire logic       level,
  output var  logic [7:0] refPhase,
  output var  logic       levelBranchPin,
  output var  logic       immediateBranchPin
);
  // phase runs free, so any stop phase wait ends within 256 cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refPhase           <= 8'h00;
      immediateBranchPin <= 1'b0;
      levelBranchPin     <= 1'b0;
    end else begin
      refPhase           <= refPhase + 8'h01;
      // pins follow the requests, held long enough for the two-flop sync
      immediateBranchPin <= fire;
      levelBranchPin     <= level;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the waveform step sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic              clk     = 1'b0;
  logic              nrst    = 1'b0;
  logic [11:0]       addr    = 12'h000;
  logic [31:0]       wrData  = 32'h0000_0000;
  logic              wrEn    = 1'b0;
  logic              rdEn    = 1'b0;
  logic              fire    = 1'b0;
  logic              level   = 1'b0;
  logic [31:0]       rdData_ff;
  logic [7:0]        refPhase;
  logic              levelBranchPin;
  logic              immediateBranchPin;
  seq_pkg::chanOut_s outCh_ff;
  seq_pkg::chanOut_s held;
  logic [7:0]        stepSyncCode_ff;
  logic [3:0]        curStep_ff;
  logic [31:0]       st;
  int                bad_count  = 0;
  int                num_checks = 0;
  int                seed       = 26576;
  int                fA;
  int                fB;
  int                r;
  int                s;
  int                expStep[$];

  always #5 clk = ~clk;

  waveform_step_sequencer u_waveform_step_sequencer (
    .clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData_ff(rdData_ff), .refPhase(refPhase),
    .levelBranchPin(levelBranchPin), .immediateBranchPin(immediateBranchPin),
    .outCh_ff(outCh_ff), .stepSyncCode_ff(stepSyncCode_ff), .curStep_ff(curStep_ff)
  );

  branch_src u_branch_src (
    .clk(clk), .nrst(nrst), .fire(fire), .level(level), .refPhase(refPhase),
    .levelBranchPin(levelBranchPin), .immediateBranchPin(immediateBranchPin)
  );

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk);
    wrEn   <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 d = rdData_ff;
  endtask

  // one step: time, control, frequency and amplitude words
  task automatic ld(input int n, input logic [31:0] t, c, f, a);
    wr(seq_pkg::OFF_STEP_MEM + 12'(n * 16), t);
    wr(seq_pkg::OFF_STEP_MEM + 12'(n * 16 + 4), c);
    wr(seq_pkg::OFF_STEP_MEM + 12'(n * 16 + 8), f);
    wr(seq_pkg::OFF_STEP_MEM + 12'(n * 16 + 12), a);
  endtask

  // bounded wait; a timeout shows up as a step mismatch
  task automatic waitStep(input int n);
    int k;
    k = 0;
    while (curStep_ff !== 4'(n) && k < 400) begin
      @(negedge clk);
      k++;
    end
    chk(36'(curStep_ff), 36'(n));
  endtask

  task automatic waitState(input int b);
    int k;
    k = 0;
    st = 32'h0000_0000;
    while (st[6 + b] !== 1'b1 && k < 80) begin
      rd(seq_pkg::OFF_STATUS, st);
      k++;
    end
    chk(36'(st[6 + b]), 36'h1);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk(outCh_ff, 36'h0);
    fA = 1000 + ({$random(seed)} % 3000);
    fB = 100 + ({$random(seed)} % 600);
    rd(12'h0F0, st);
    chk(36'(st), 36'h0);
    wr(seq_pkg::OFF_NORM_FREQ, 32'h0000_0ABC);
    wr(seq_pkg::OFF_NORM_AMP, 32'h0000_0123);
    wr(seq_pkg::OFF_NORM_WAVE, 32'h0000_0007);
    ld(0, 32'h0000_000A, 32'h05A0_0000, 32'h0002_00C8, 32'h0010_0064);
    ld(1, 32'h0000_0014, 32'h0110_0000, 32'h0002_0000 | 32'(fA), 32'h0020_012C);
    ld(2, 32'h0000_0014, 32'h0220_0000, 32'h0001_0000, 32'h0031_0000);
    ld(3, 32'h0000_0014, 32'h0330_0003, 32'(fB), 32'h0040_0190);
    ld(4, 32'h0000_0014, 32'h0440_0002, 32'h0000_02BC, 32'h0050_01F4);
    wr(seq_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (12) @(negedge clk);
    chk(36'(curStep_ff), 36'h0);
    chk(outCh_ff, {4'h1, 16'h00C8, 16'h0064});
    // run 0 resumes an ending step, run 1 stops, run 2 resumes onward
    for (r = 0; r < 3; r++) begin
      wr(seq_pkg::OFF_STEP_MEM + 12'h034, (r == 2) ? 32'h0330_0001 : 32'h0330_0003);
      wr(seq_pkg::OFF_CMD, 32'h0000_0001);
      expStep = {1, 2, 3};
      while (expStep.size() > 0) begin
        s = expStep.pop_front();
        waitStep(s);
        repeat (8) @(negedge clk);
        chk(36'(outCh_ff.wave), 36'(s + 1));
        chk(36'(stepSyncCode_ff), 36'(s * 17));
        if (s == 2)
          chk(outCh_ff, {4'h3, 16'(fA), 16'h012C});
        if (s == 3)
          chk(outCh_ff, {4'h4, 16'(fB), 16'h0190});
        if (s == 4)
          chk(outCh_ff, {4'h5, 16'h02BC, 16'h01F4});
        if (s == 3) begin
          waitState(4);
          held = outCh_ff;
          repeat (10) @(negedge clk);
          chk(outCh_ff, held);
          wr(seq_pkg::OFF_CMD, (r == 1) ? 32'h0000_0002 : 32'h0000_0004);
          if (r == 2)
            expStep.push_back(4);
        end
      end
      waitStep(0);
      waitState(0);
      chk(outCh_ff, {4'h1, 16'h00C8, 16'h0064});
      chk(36'(stepSyncCode_ff), 36'h5A);
    end
    // pin edge, then soft key, jump from step 1 straight to step 4 while it runs;
    // the second run has a stop phase set, which must not delay the jump
    for (r = 0; r < 2; r++) begin
      wr(seq_pkg::OFF_STEP_MEM + 12'h014, (r == 0) ? 32'h0114_0010 : 32'h0114_0014);
      wr(seq_pkg::OFF_CMD, 32'h0000_0001);
      waitStep(1);
      repeat (8) @(posedge clk);
      if (r == 0) begin
        fire <= 1'b1;
        repeat (4) @(posedge clk);
        fire <= 1'b0;
      end else begin
        wr(seq_pkg::OFF_CMD, 32'h0000_0008);
      end
      waitStep(4);
      waitStep(0);
      waitState(0);
    end
    // stop phase one count behind the free phase, so the wait is long;
    // the level pin, high all along, may only act once that wait is over
    level <= 1'b1;
    wr(seq_pkg::OFF_STEP_MEM + 12'h018, {refPhase - 8'h01, 8'h02, 16'(fA)});
    wr(seq_pkg::OFF_STEP_MEM + 12'h014, 32'h0110_400C);
    wr(seq_pkg::OFF_CMD, 32'h0000_0001);
    waitState(3);
    repeat (20) @(negedge clk);
    chk(outCh_ff, {4'h2, 16'(fA), 16'h012C});
    waitStep(4);
    waitStep(0);
    waitState(0);
    level <= 1'b0;
    wr(seq_pkg::OFF_CTRL, 32'h0000_0000);
    repeat (4) @(negedge clk);
    chk(outCh_ff, {4'h7, 16'h0ABC, 16'h0123});
    end_sim();
  end
endmodule
`default_nettype wire
